// file: verilog/dtcw_consts.vh
`ifndef DTCW_CONSTS_VH
`define DTCW_CONSTS_VH

// ----------------------------------------------------------------
// Instruction register
// ----------------------------------------------------------------
`define DTCW_IR_W          5
`define DTCW_IR_CONTROL    5'h0A
`define DTCW_IR_WATCH      5'h1C
`define DTCW_IR_BYPASS     5'h1F
`define DTCW_IR_CAPTURE    5'h01

// ----------------------------------------------------------------
// Control register field positions
// ----------------------------------------------------------------
`define DTCW_CTL_W         32
`define DTCW_CTL_RST_OCC   31
`define DTCW_CTL_PSE       15
`define DTCW_CTL_VSEL      14
`define DTCW_CTL_BRK       12
`define DTCW_CTL_DM        3

// ----------------------------------------------------------------
// Watch control and bypass
// ----------------------------------------------------------------
`define DTCW_WATCH_W       8
`define DTCW_WATCH_EN      0
`define DTCW_WATCH_RST     1'h0
`define DTCW_BYPASS_RST    1'h0

// ----------------------------------------------------------------
// Reset values, vectors and codes
// ----------------------------------------------------------------
`define DTCW_RST_OCC_RST   1'h1
`define DTCW_VEC_NORMAL    32'hBFC00480
`define DTCW_VEC_DEBUG     32'hFF200200
`define DTCW_EXC_WATCH     5'h17

`endif

// file: verilog/dtcw_top.v
`timescale 1ns/1ps
// Contract
// - Service-enable 1 means probe services debug memory
// - Service-enable mirrored read-only to processor bit 0
// - Readback shows value only after core applied
// - Vector select picks normal or debug vector
// - Settings before break govern the handler
// - Break write 1 requests; cleared on debug entry
// - Break in debug mode waits for exit
// - Pending break restarts a stopped clock
// - Break reads pending; writing 0 ignored
// - Bit 3 shows debug mode, resets 0
// - Watch bit 0 selects debug watch mode
// - Debug watch blocks watch writes outside debug
// - Debug watch match raises code 23 exception
// - Debug watch saves PC to debug return
// - Bypass is one bit, captures zero
// - TDI and TMS sampled on rising TCK
// - TDO changes on falling TCK
// - Probe rewrites until readback confirms change
// - Control update needs reset-occurred clear
`include "dtcw_consts.vh"

module dtcw_top (
  // Core clock, reset, freeze
  input  wire        i_core_clk,
  input  wire        i_rst_n,
  input  wire        i_ce,
  // Serial test port
  input  wire        i_tck,
  input  wire        i_tms,
  input  wire        i_tdi,
  input  wire        i_trst_n,
  output reg         o_tdo,
  // Processor status
  input  wire        i_cpu_in_debug,
  input  wire        i_cpu_rst,
  input  wire        i_clk_stable,
  input  wire        i_boot_debug,
  // Watch unit
  input  wire        i_watch_match,
  input  wire        i_watch_wr,
  input  wire [31:0] i_pc,
  output wire        o_watch_wr_en,
  output reg         o_watch_debug_exc,
  output reg         o_normal_watch_exc,
  output reg  [4:0]  o_debug_exception_code,
  output reg  [31:0] o_debug_return_pc,
  // Processor debug controls
  output reg         o_probe_service_enable,
  output reg  [31:0] o_debug_vector,
  output wire        o_debug_req,
  output wire        o_clock_wake
);

  // ----------------------------------------------------------------
  // TAP states, one-hot
  // ----------------------------------------------------------------
  localparam [15:0] S_TLR = 16'h0001;
  localparam [15:0] S_RTI = 16'h0002;
  localparam [15:0] S_SDS = 16'h0004;
  localparam [15:0] S_CDR = 16'h0008;
  localparam [15:0] S_SHD = 16'h0010;
  localparam [15:0] S_E1D = 16'h0020;
  localparam [15:0] S_PD  = 16'h0040;
  localparam [15:0] S_E2D = 16'h0080;
  localparam [15:0] S_UDR = 16'h0100;
  localparam [15:0] S_SIS = 16'h0200;
  localparam [15:0] S_CIR = 16'h0400;
  localparam [15:0] S_SHI = 16'h0800;
  localparam [15:0] S_E1I = 16'h1000;
  localparam [15:0] S_PI  = 16'h2000;
  localparam [15:0] S_E2I = 16'h4000;
  localparam [15:0] S_UIR = 16'h8000;

  reg  [1:0]  rst_s;
  reg  [1:0]  trst_s;
  reg  [2:0]  tck_s;
  reg  [1:0]  tms_s;
  reg  [1:0]  tdi_s;
  reg  [15:0] st;
  reg  [15:0] next_st;
  reg  [`DTCW_IR_W-1:0]  ir;
  reg  [`DTCW_IR_W-1:0]  ir_sr;
  reg  [`DTCW_CTL_W-1:0] dr_sr;
  reg         watch_mode;
  reg         rst_occ;
  reg         req_pse;
  reg         req_vsel;
  reg         req_brk;
  reg         req_pend;
  reg         pse_eff;
  reg         vsel_eff;
  reg         brk_pend;
  reg         dm_q;
  reg         boot_done;
  wire        core_rst_n;
  wire        tap_rst_n;
  wire        tck_rise;
  wire        tck_fall;
  wire        ctl_ok;
  wire        dm_entry;
  wire [`DTCW_CTL_W-1:0] ctl_rd;

  // ----------------------------------------------------------------
  // Reset release and pin synchronisers
  // ----------------------------------------------------------------
  // Core reset released through two flops
  always @(posedge i_core_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      rst_s <= 2'h0;
    end else begin
      rst_s <= {rst_s[0], 1'b1};
    end
  end

  assign core_rst_n = rst_s[1];

  // Test reset acts at once; its release is a pin edge, so it crosses
  // two flops before the TAP state may leave reset
  always @(posedge i_core_clk or negedge i_trst_n) begin
    if (!i_trst_n) begin
      trst_s <= 2'h0;
    end else begin
      trst_s <= {trst_s[0], 1'b1};
    end
  end

  assign tap_rst_n = core_rst_n & trst_s[1];

  // Pins cross two flops; the third tck stage only feeds edge finding
  always @(posedge i_core_clk or negedge core_rst_n) begin
    if (!core_rst_n) begin
      tck_s <= 3'h0;
      tms_s <= 2'h3;
      tdi_s <= 2'h0;
    end else if (i_ce) begin
      tck_s <= {tck_s[1:0], i_tck};
      tms_s <= {tms_s[0], i_tms};
      tdi_s <= {tdi_s[0], i_tdi};
    end
  end

  // Edge detectors; needs several core cycles per TCK phase
  assign tck_rise = tck_s[1] & ~tck_s[2];
  assign tck_fall = ~tck_s[1] & tck_s[2];

  // ----------------------------------------------------------------
  // TAP state machine
  // ----------------------------------------------------------------
  // Next state from the sampled mode select
  always @* begin
    case (st)
      S_TLR:   next_st = tms_s[1] ? S_TLR : S_RTI;
      S_RTI:   next_st = tms_s[1] ? S_SDS : S_RTI;
      S_SDS:   next_st = tms_s[1] ? S_SIS : S_CDR;
      S_CDR:   next_st = tms_s[1] ? S_E1D : S_SHD;
      S_SHD:   next_st = tms_s[1] ? S_E1D : S_SHD;
      S_E1D:   next_st = tms_s[1] ? S_UDR : S_PD;
      S_PD:    next_st = tms_s[1] ? S_E2D : S_PD;
      S_E2D:   next_st = tms_s[1] ? S_UDR : S_SHD;
      S_UDR:   next_st = tms_s[1] ? S_SDS : S_RTI;
      S_SIS:   next_st = tms_s[1] ? S_TLR : S_CIR;
      S_CIR:   next_st = tms_s[1] ? S_E1I : S_SHI;
      S_SHI:   next_st = tms_s[1] ? S_E1I : S_SHI;
      S_E1I:   next_st = tms_s[1] ? S_UIR : S_PI;
      S_PI:    next_st = tms_s[1] ? S_E2I : S_PI;
      S_E2I:   next_st = tms_s[1] ? S_UIR : S_SHI;
      S_UIR:   next_st = tms_s[1] ? S_SDS : S_RTI;
      default: next_st = S_TLR;
    endcase
  end

  // Control readback shows only values the core has applied
  assign ctl_rd = {rst_occ, 15'h0000,
                   pse_eff, vsel_eff, 1'b0, brk_pend,
                   8'h00, i_cpu_in_debug, 3'h0};

  // Update is refused while reset-occurred stays set
  assign ctl_ok = ~rst_occ | ~dr_sr[`DTCW_CTL_RST_OCC];

  // State, instruction and data shifting on rising TCK
  always @(posedge i_core_clk or negedge tap_rst_n) begin
    if (!tap_rst_n) begin
      st         <= S_TLR;
      ir         <= `DTCW_IR_BYPASS;
      ir_sr      <= `DTCW_IR_CAPTURE;
      dr_sr      <= 32'h00000000;
      watch_mode <= `DTCW_WATCH_RST;
    end else if (i_ce && tck_rise) begin
      st <= next_st;
      if (st == S_TLR) begin
        ir <= `DTCW_IR_BYPASS;
      end
      if (st == S_CIR) begin
        ir_sr <= `DTCW_IR_CAPTURE;
      end
      if (st == S_SHI) begin
        ir_sr <= {tdi_s[1], ir_sr[`DTCW_IR_W-1:1]};
      end
      if (st == S_UIR) begin
        ir <= ir_sr;
      end
      if (st == S_CDR) begin
        case (ir)
          `DTCW_IR_CONTROL: dr_sr <= ctl_rd;
          `DTCW_IR_WATCH:   dr_sr <= {31'h00000000, watch_mode};
          default:          dr_sr <= {31'h00000000,
                                      `DTCW_BYPASS_RST};
        endcase
      end
      if (st == S_SHD) begin
        case (ir)
          `DTCW_IR_CONTROL: dr_sr <= {tdi_s[1], dr_sr[31:1]};
          `DTCW_IR_WATCH:   dr_sr <= {24'h000000, tdi_s[1], dr_sr[7:1]};
          default:          dr_sr <= {31'h00000000, tdi_s[1]};
        endcase
      end
      if (st == S_UDR && ir == `DTCW_IR_WATCH) begin
        watch_mode <= dr_sr[`DTCW_WATCH_EN];
      end
    end
  end

  // Output bit changes on falling TCK, stable for the next rise
  always @(posedge i_core_clk or negedge tap_rst_n) begin
    if (!tap_rst_n) begin
      o_tdo <= 1'b0;
    end else if (i_ce && tck_fall) begin
      if (st == S_SHI) begin
        o_tdo <= ir_sr[0];
      end else if (st == S_SHD) begin
        o_tdo <= dr_sr[0];
      end
    end
  end

  // ----------------------------------------------------------------
  // Control register requests and core-side application
  // ----------------------------------------------------------------
  assign dm_entry = i_cpu_in_debug & ~dm_q;

  // Requests cross once the core clock is settled; a write made while
  // it relocks is dropped and the probe must retry
  always @(posedge i_core_clk or negedge core_rst_n) begin
    if (!core_rst_n) begin
      rst_occ   <= `DTCW_RST_OCC_RST;
      req_pse   <= 1'b0;
      req_vsel  <= 1'b0;
      req_brk   <= 1'b0;
      req_pend  <= 1'b0;
      pse_eff   <= 1'b0;
      vsel_eff  <= 1'b0;
      brk_pend  <= 1'b0;
      dm_q      <= 1'b0;
      boot_done <= 1'b0;
    end else if (i_ce) begin
      dm_q <= i_cpu_in_debug;
      // Processor reset keeps the flag set; set wins over clear
      if (i_cpu_rst) begin
        rst_occ <= 1'b1;
      end else if (tck_rise && st == S_UDR &&
                   ir == `DTCW_IR_CONTROL && ctl_ok) begin
        rst_occ <= dr_sr[`DTCW_CTL_RST_OCC];
      end
      if (tck_rise && st == S_UDR && ir == `DTCW_IR_CONTROL && ctl_ok) begin
        req_pse  <= dr_sr[`DTCW_CTL_PSE];
        req_vsel <= dr_sr[`DTCW_CTL_VSEL];
        req_brk  <= dr_sr[`DTCW_CTL_BRK];
        req_pend <= 1'b1;
      end else if (req_pend) begin
        req_pend <= 1'b0;
      end
      if (!boot_done) begin
        // Boot strap picks the starting debug setup
        boot_done <= 1'b1;
        pse_eff   <= i_boot_debug;
        vsel_eff  <= i_boot_debug;
        brk_pend  <= i_boot_debug;
      end else begin
        // Settings land before or with the break, never after
        if (req_pend && i_clk_stable) begin
          pse_eff  <= req_pse;
          vsel_eff <= req_vsel;
        end
        // Write of 0 ignored; a new request beats debug entry
        if (req_pend && i_clk_stable && req_brk) begin
          brk_pend <= 1'b1;
        end else if (dm_entry) begin
          brk_pend <= 1'b0;
        end
      end
    end
  end

  // Request held off while already in debug mode
  assign o_debug_req  = brk_pend & ~i_cpu_in_debug;
  assign o_clock_wake = brk_pend;

  // ----------------------------------------------------------------
  // Processor-side outputs and watch handling
  // ----------------------------------------------------------------
  // Watch writes pass only in normal mode or while debugging
  assign o_watch_wr_en = i_watch_wr &
                         (~watch_mode | i_cpu_in_debug);

  // Registered copies toward the processor
  always @(posedge i_core_clk or negedge core_rst_n) begin
    if (!core_rst_n) begin
      o_probe_service_enable <= 1'b0;
      o_debug_vector         <= `DTCW_VEC_NORMAL;
      o_watch_debug_exc      <= 1'b0;
      o_normal_watch_exc     <= 1'b0;
      o_debug_exception_code <= 5'h00;
      o_debug_return_pc      <= 32'h00000000;
    end else if (i_ce) begin
      o_probe_service_enable <= pse_eff;
      o_debug_vector <= vsel_eff ? `DTCW_VEC_DEBUG
                                 : `DTCW_VEC_NORMAL;
      o_watch_debug_exc  <= i_watch_match & watch_mode;
      o_normal_watch_exc <= i_watch_match & ~watch_mode;
      if (i_watch_match && watch_mode) begin
        o_debug_exception_code <= `DTCW_EXC_WATCH;
        o_debug_return_pc      <= i_pc;
      end
    end
  end

endmodule // dtcw_top

// file: bench/dtcw_monitor.sv
`timescale 1ns/1ps
module dtcw_monitor (
  // Clock and resets
  input wire        i_core_clk,
  input wire        i_rst_n,
  input wire        i_trst_n,
  // Test port and processor side
  input wire        i_tck,
  input wire        o_tdo,
  input wire        i_cpu_in_debug,
  input wire        i_watch_match,
  input wire        i_watch_wr,
  input wire [31:0] i_pc,
  // Watch and debug outputs
  input wire        o_watch_wr_en,
  input wire        o_watch_debug_exc,
  input wire        o_normal_watch_exc,
  input wire [4:0]  o_debug_exception_code,
  input wire [31:0] o_debug_return_pc,
  input wire [31:0] o_debug_vector,
  input wire        o_debug_req,
  input wire        o_clock_wake
);
  // ----------------
  // Core clock checks
  // ----------------
  default clocking cb @(posedge i_core_clk); endclocking
  default disable iff (!i_rst_n);
  // Fall is seen two or three core cycles late, so tck was low just before
  property p_tdo;
    $changed(o_tdo) |-> !i_trst_n || !$past(i_tck) || !$past(i_tck, 2);
  endproperty
  property p_wr_cause;
    o_watch_wr_en |-> i_watch_wr;
  endproperty
  property p_wr_dbg;
    i_watch_wr && i_cpu_in_debug |-> o_watch_wr_en;
  endproperty
  property p_code;
    o_watch_debug_exc |-> o_debug_exception_code == 5'h17;
  endproperty
  property p_pc;
    $rose(o_watch_debug_exc) |-> o_debug_return_pc == $past(i_pc);
  endproperty
  property p_cause;
    o_watch_debug_exc || o_normal_watch_exc |-> $past(i_watch_match);
  endproperty
  property p_req;
    o_debug_req |-> !i_cpu_in_debug && o_clock_wake;
  endproperty
  property p_vec;
    o_debug_vector == 32'hBFC00480 || o_debug_vector == 32'hFF200200;
  endproperty
  a_tdo: assert property (p_tdo) else $error("tdo timing");
  a_wr_cause: assert property (p_wr_cause) else $error("wr_en");
  a_wr_dbg: assert property (p_wr_dbg) else $error("wr block");
  a_code: assert property (p_code) else $error("exc code");
  a_pc: assert property (p_pc) else $error("return pc");
  a_cause: assert property (p_cause) else $error("exc cause");
  a_req: assert property (p_req) else $error("debug req");
  a_vec: assert property (p_vec) else $error("vector");
  c_dexc: cover property (o_watch_debug_exc);
  c_req: cover property ($fell(o_debug_req));
  c_vec: cover property (o_debug_vector == 32'hFF200200);
endmodule // dtcw_monitor

bind dtcw_top dtcw_monitor u_mon (
  .i_core_clk, .i_rst_n, .i_trst_n, .i_tck, .o_tdo, .i_cpu_in_debug,
  .i_watch_match, .i_watch_wr, .i_pc, .o_watch_wr_en, .o_watch_debug_exc,
  .o_normal_watch_exc, .o_debug_exception_code, .o_debug_return_pc,
  .o_debug_vector, .o_debug_req, .o_clock_wake
);

// file: bench/dtcw_probe.sv
`timescale 1ns/1ps
module dtcw_probe (
  // Serial port toward the device
  output logic o_tck,
  output logic o_tms,
  output logic o_tdi,
  input  wire  i_tdo
);
  logic t;
  // Clock parks low between frames
  initial begin
    o_tck = 1'b0;
    o_tms = 1'b1;
    o_tdi = 1'b0;
  end
  // ----------------
  // Scan tasks
  // ----------------
  // One 320 ns test clock, an eighth of the core rate
  task automatic step(input logic tms, input logic tdi);
    o_tms = tms;
    o_tdi = tdi;
    #160;
    t = i_tdo;
    o_tck = 1'b1;
    #160;
    o_tck = 1'b0;
  endtask
  // Mode line pattern, read from bit 0
  task automatic walk(input logic [3:0] p, input int c);
    for (int i = 0; i < c; i++) step(p[i], o_tdi);
  endtask
  task automatic tap_reset();
    walk(4'hF, 4);
    walk(4'h1, 2);
  endtask
  // Instruction, then n data bits LSB first, back to idle
  task automatic scan(input logic [4:0] ir, input logic [31:0] wd,
                      input int n, output logic [31:0] rd);
    rd = 32'h0;
    walk(4'h3, 4);
    for (int i = 0; i < 5; i++) step(i == 4, ir[i]);
    walk(4'h3, 4);
    for (int i = 0; i < n; i++) begin
      step(i == n - 1, wd[i]);
      rd[i] = t;
    end
    walk(4'h1, 2);
    // Released line must not keep showing the last bit
    o_tdi = ~o_tdi;
  endtask
endmodule // dtcw_probe

// file: bench/test_debug_tap_control_watch.sv
`timescale 1ns/1ps
module test_debug_tap_control_watch;
  // Inputs valued at time zero
  logic        i_core_clk = 1'b0;
  logic        i_rst_n = 1'b0;
  logic        i_trst_n = 1'b1;
  logic        i_cpu_in_debug = 1'b0;
  logic        i_clk_stable = 1'b1;
  logic        i_cpu_rst = 1'b0;
  logic        i_boot_debug = 1'b0;
  logic        i_watch_match = 1'b0;
  logic        i_watch_wr = 1'b0;
  logic [31:0] i_pc = 32'h0;
  wire         i_tck, i_tms, i_tdi, o_tdo, o_watch_wr_en, o_watch_debug_exc;
  wire         o_normal_watch_exc, o_probe_service_enable, o_debug_req;
  wire         o_clock_wake;
  wire [4:0]   o_debug_exception_code;
  wire [31:0]  o_debug_return_pc, o_debug_vector;
  logic [31:0] rd;
  int          fail_count = 0;
  int          checks = 0;
  int          cyc = 0;
  // Mode, debug, write, match | write enable, debug exc, normal exc
  logic [6:0]  rows [4] = '{7'h1D, 7'h5A, 7'h74, 7'h3D};

  dtcw_top uut (
    .i_core_clk, .i_rst_n, .i_ce(1'b1), .i_tck, .i_tms, .i_tdi, .i_trst_n,
    .o_tdo, .i_cpu_in_debug, .i_cpu_rst, .i_clk_stable,
    .i_boot_debug, .i_watch_match, .i_watch_wr, .i_pc, .o_watch_wr_en,
    .o_watch_debug_exc, .o_normal_watch_exc, .o_debug_exception_code,
    .o_debug_return_pc, .o_probe_service_enable, .o_debug_vector,
    .o_debug_req, .o_clock_wake
  );
  dtcw_probe u_probe (.o_tck(i_tck), .o_tms(i_tms), .o_tdi(i_tdi),
                      .i_tdo(o_tdo));

  always #20 i_core_clk = ~i_core_clk;
  // Run needs about 6700 cycles; a hang ends here
  always @(posedge i_core_clk) begin
    cyc <= cyc + 1;
    if (cyc == 30000) begin
      fail_count++;
      wrap_up();
    end
  end

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      fail_count++;
      $display("[FAIL] %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic ctl(input logic [31:0] w);
    u_probe.scan(5'h0A, w, 32, rd);
  endtask
  task automatic wat(input logic [7:0] w);
    u_probe.scan(5'h1C, {24'h0, w}, 8, rd);
  endtask
  task automatic cpu_dbg(input logic v);
    @(negedge i_core_clk);
    i_cpu_in_debug = v;
    repeat (2) @(negedge i_core_clk);
  endtask
  task automatic wrap_up();
    $display("checks %0d mismatches %0d", checks, fail_count);
    if (fail_count == 0 && checks > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask

  initial begin
    repeat (20) @(negedge i_core_clk);
    i_rst_n = 1'b1;
    repeat (4) @(negedge i_core_clk);
    chk(o_debug_vector, 32'hBFC00480);
    chk(o_probe_service_enable, 32'h0);
    u_probe.tap_reset();
    $display("test reset done");
    foreach (rows[r]) begin
      wat({7'h7F, rows[r][6]});
      wat({7'h7F, rows[r][6]});
      chk(rd, {31'h0, rows[r][6]});
      @(negedge i_core_clk);
      {i_cpu_in_debug, i_watch_wr, i_watch_match} = rows[r][5:3];
      i_pc = 32'h00400000 + r;
      @(negedge i_core_clk);
      chk(o_watch_wr_en, rows[r][2]);
      chk(o_watch_debug_exc, rows[r][1]);
      chk(o_normal_watch_exc, rows[r][0]);
      if (rows[r][1]) begin
        chk(o_debug_exception_code, 32'h17);
        chk(o_debug_return_pc, i_pc);
      end
      {i_cpu_in_debug, i_watch_wr, i_watch_match} = 3'h0;
    end
    $display("test watch done");
    ctl(32'h8000D000);
    chk(rd, 32'h80000000);
    ctl(32'h7FFFEFFF);
    chk(rd, 32'h80000000);
    ctl(32'h0000C000);
    chk(rd, 32'h0000C000);
    chk(o_probe_service_enable, 32'h1);
    chk(o_debug_vector, 32'hFF200200);
    $display("test control done");
    ctl(32'h0000D000);
    chk(o_debug_req, 32'h1);
    chk(o_debug_vector, 32'hFF200200);
    chk(o_clock_wake, 32'h1);
    ctl(32'h0000C000);
    chk(rd, 32'h0000D000);
    chk(o_debug_req, 32'h1);
    cpu_dbg(1'b1);
    chk(o_debug_req, 32'h0);
    ctl(32'h0000D000);
    chk(rd, 32'h0000C008);
    chk(o_clock_wake, 32'h1);
    cpu_dbg(1'b0);
    chk(o_debug_req, 32'h1);
    cpu_dbg(1'b1);
    cpu_dbg(1'b0);
    chk(o_clock_wake, 32'h0);
    $display("test break done");
    // Write during an unsettled clock is lost, so it is written again
    @(negedge i_core_clk);
    i_clk_stable = 1'b0;
    ctl(32'h00008000);
    @(negedge i_core_clk);
    i_clk_stable = 1'b1;
    ctl(32'h00008000);
    chk(rd, 32'h0000C000);
    ctl(32'h00008000);
    chk(rd, 32'h00008000);
    chk(o_debug_vector, 32'hBFC00480);
    chk(o_probe_service_enable, 32'h1);
    $display("test clock change done");
    u_probe.scan(5'h1F, 32'h1, 1, rd);
    chk(rd, 32'h0);
    wat(8'h01);
    @(negedge i_core_clk);
    i_trst_n = 1'b0;
    @(negedge i_core_clk);
    i_trst_n = 1'b1;
    u_probe.tap_reset();
    wat(8'h00);
    chk(rd, 32'h0);
    $display("test bypass and test reset done");
    // Processor reset sets reset-occurred again and locks updates out
    @(negedge i_core_clk);
    i_cpu_rst = 1'b1;
    @(negedge i_core_clk);
    i_cpu_rst = 1'b0;
    ctl(32'h8000C000);
    chk(rd, 32'h80008000);
    ctl(32'h8000C000);
    chk(rd, 32'h80008000);
    chk(o_debug_vector, 32'hBFC00480);
    $display("test processor reset done");
    // Mid-run core reset with the strap high starts in debug setup
    @(negedge i_core_clk);
    i_boot_debug = 1'b1;
    i_rst_n = 1'b0;
    @(negedge i_core_clk);
    chk(o_debug_vector, 32'hBFC00480);
    chk(o_clock_wake, 32'h0);
    i_rst_n = 1'b1;
    repeat (4) @(negedge i_core_clk);
    chk(o_probe_service_enable, 32'h1);
    chk(o_debug_vector, 32'hFF200200);
    chk(o_debug_req, 32'h1);
    chk(o_clock_wake, 32'h1);
    u_probe.tap_reset();
    ctl(32'h0000C000);
    chk(rd, 32'h8000D000);
    $display("test core reset done");
    wrap_up();
  end
endmodule // test_debug_tap_control_watch
